// file: hw/lcd_dec_defines.svh
// timing counts, field positions and reset values of the decoder
`ifndef LCD_DEC_DEFINES_SVH
`define LCD_DEC_DEFINES_SVH
`define CLK_PERIOD_NS 40
`define EXEC_TIME_NS 72000
`define CLEAR_TIME_NS 1600000
`define EXEC_CYCLES (`EXEC_TIME_NS / `CLK_PERIOD_NS)
`define CLEAR_CYCLES (`CLEAR_TIME_NS / `CLK_PERIOD_NS)
`define TEXT_WORDS 64
`define SPACE_WORD 16'h2020
`define AC_RESET 7'h00
`define REV_IDX_RESET 2'h0
`define TEXT_ADDR_MASK 7'h3F
`define ICON_ADDR_MASK 7'h0F
`define HORZ_MASK 7'h0F
`define FS_WIDTH_BIT 4
`define FS_SET_BIT 2
`define FS_GFX_BIT 1
`define SHIFT_TARGET_BIT 3
`define SHIFT_DIR_BIT 2
`endif

// file: hw/lcd_dec_pkg.sv
// types shared by the instruction decoder files
package lcd_dec_pkg;
    typedef enum logic [2:0] {
        TGT_TEXT = 3'b000,
        TGT_GLYPH = 3'b001,
        TGT_ICON = 3'b010,
        TGT_BITMAP = 3'b011
    } memTarget_t;

    typedef enum logic [1:0] {
        EX_IDLE = 2'b00,
        EX_BUSY = 2'b01,
        EX_CLEAR = 2'b10
    } execState_t;

    typedef struct packed {
        logic isData;
        logic isRead;
        logic [7:0] data;
    } hostXfer_t;

    typedef struct packed {
        logic displayOn;
        logic cursorOn;
        logic blinkOn;
        logic graphicOn;
        logic sleeping;
        logic standby;
        logic [3:0] reversed;
        logic [1:0] topLine;
        logic [5:0] shift;
        logic [5:0] scroll;
    } panelCtrl_t;
endpackage

// file: hw/host_pin_sync.sv
// synchroniser and strobe edge detector for the host parallel bus pins
`timescale 1ns/1ps
module host_pin_sync (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // host pins
    input wire logic enablePin,
    input wire logic cmdDataPin,
    input wire logic readPin,
    input wire logic [7:0] dataPin,
    // synchronised transfer
    output lcd_dec_pkg::hostXfer_t xfer,
    output logic writeStb,
    output logic readStart,
    output logic readEnd,
    output logic readActive
);
    logic [10:0] meta_r;
    logic [10:0] sync_r;
    logic enPrev_r;
    logic enPrev2_r;
    lcd_dec_pkg::hostXfer_t hold_r;

    // two flops per pin; only sync_r is looked at
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            meta_r <= 11'h000;
            sync_r <= 11'h000;
            enPrev_r <= 1'b0;
            enPrev2_r <= 1'b0;
        end
        else
        begin
            meta_r <= {enablePin, cmdDataPin, readPin, dataPin};
            sync_r <= meta_r;
            enPrev_r <= sync_r[10];
            enPrev2_r <= enPrev_r;
        end
    end

    // keep the last sample taken while enable is high, since data
    // hold after the falling edge is shorter than one clock
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            hold_r <= '0;
        else if (sync_r[10])
            hold_r <= sync_r[9:0];
    end

    assign xfer = hold_r;
    assign writeStb = enPrev_r & ~sync_r[10] & ~hold_r.isRead;
    assign readEnd = enPrev_r & ~sync_r[10] & hold_r.isRead;
    // start one clock late so hold_r already holds this pulse's select
    // bits; earlier the decoder would see the previous transfer's
    assign readStart = sync_r[10] & enPrev_r & ~enPrev2_r & hold_r.isRead;
    assign readActive = sync_r[10] & sync_r[8];
endmodule

// file: hw/lcd_instruction_decoder.sv
// instruction decoder and address counter of the graphic panel controller
`timescale 1ns/1ps
`include "lcd_dec_defines.svh"
module lcd_instruction_decoder #(
    parameter int EXEC_CYCLES = `EXEC_CYCLES,
    parameter int CLEAR_CYCLES = `CLEAR_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // host bus pins
    input wire logic hostEnable,
    input wire logic commandDataSelect,
    input wire logic readSelect,
    input wire logic [7:0] dbIn,
    output logic [7:0] dbOut,
    output logic dbOe,
    // controller state
    output logic busyFlag,
    output logic busWidth8,
    output logic extendedSet,
    output logic [6:0] addressCounter,
    output logic [6:0] bitmapRow,
    output lcd_dec_pkg::memTarget_t memTarget,
    output lcd_dec_pkg::panelCtrl_t panel
);
    lcd_dec_pkg::hostXfer_t xfer;
    lcd_dec_pkg::execState_t exec_r;
    lcd_dec_pkg::memTarget_t target_r;
    lcd_dec_pkg::panelCtrl_t panel_r;
    logic writeStb, readStart, readEnd, readActive;
    logic [3:0] wrNib_r;
    logic wrNibPhase_r;
    logic byteStb_r;
    lcd_dec_pkg::hostXfer_t byte_r;
    logic [31:0] count_r;
    logic [5:0] fillIdx_r;
    logic busy_r, width8_r, ext_r, incDir_r, entryShift_r;
    logic wordPhase_r, gfxPhase_r, primed_r, rdByteSel_r, rdNib_r;
    logic scrollSel_r;
    logic [6:0] ac_r, row_r;
    logic [7:0] hiByte_r, dbOut_r;
    logic dbOe_r;
    logic [1:0] revIdx_r;
    logic [15:0] textMem [`TEXT_WORDS];
    logic [15:0] rdWord;
    logic [7:0] rdByte;
    logic cmdFire, dataFire, wordDone, rdByteDone, rdStep;
    logic [7:0] cmd;

    host_pin_sync u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .enablePin(hostEnable),
        .cmdDataPin(commandDataSelect),
        .readPin(readSelect),
        .dataPin(dbIn),
        .xfer(xfer),
        .writeStb(writeStb),
        .readStart(readStart),
        .readEnd(readEnd),
        .readActive(readActive)
    );

    // step an address up or down by one within seven bits
    function automatic logic [6:0] stepAddr(input logic [6:0] a,
                                            input logic up);
        stepAddr = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    endfunction

    // step a six bit position up or down
    function automatic logic [5:0] stepPos(input logic [5:0] p,
                                           input logic up);
        stepPos = up ? 6'(p + 6'h01) : 6'(p - 6'h01);
    endfunction

    // byte assembly; 4-bit bus takes the upper lines, high nibble first
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            wrNibPhase_r <= 1'b0;
            wrNib_r <= 4'h0;
            byteStb_r <= 1'b0;
            byte_r <= '0;
        end
        else
        begin
            byteStb_r <= 1'b0;
            if (writeStb && width8_r)
            begin
                byteStb_r <= 1'b1;
                byte_r <= xfer;
            end
            else if (writeStb && !wrNibPhase_r)
            begin
                wrNib_r <= xfer.data[7:4];
                wrNibPhase_r <= 1'b1;
            end
            else if (writeStb)
            begin
                byteStb_r <= 1'b1;
                byte_r <= '{xfer.isData, 1'b0, {wrNib_r, xfer.data[7:4]}};
                wrNibPhase_r <= 1'b0;
            end
        end
    end

    // a byte is acted on only when not busy; otherwise dropped
    assign cmdFire = byteStb_r & ~busy_r & ~byte_r.isData;
    assign dataFire = byteStb_r & ~busy_r & byte_r.isData;
    assign cmd = byte_r.data;
    assign wordDone = dataFire & wordPhase_r;
    assign rdByteDone = readEnd & (width8_r | rdNib_r);
    assign rdStep = rdByteDone & xfer.isData & primed_r & rdByteSel_r;

    // busy flag and execution timer; clear also sweeps text memory
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            exec_r <= lcd_dec_pkg::EX_IDLE;
            busy_r <= 1'b0;
            count_r <= 32'h0;
            fillIdx_r <= 6'h00;
        end
        else
        begin
            case (exec_r)
                lcd_dec_pkg::EX_IDLE:
                begin
                    if (cmdFire && !ext_r && cmd == 8'h01)
                    begin
                        exec_r <= lcd_dec_pkg::EX_CLEAR;
                        busy_r <= 1'b1;
                        count_r <= 32'(CLEAR_CYCLES - 1);
                        fillIdx_r <= 6'h00;
                    end
                    else if (cmdFire || dataFire)
                    begin
                        exec_r <= lcd_dec_pkg::EX_BUSY;
                        busy_r <= 1'b1;
                        count_r <= 32'(EXEC_CYCLES - 1);
                    end
                end
                lcd_dec_pkg::EX_BUSY, lcd_dec_pkg::EX_CLEAR:
                begin
                    fillIdx_r <= 6'(fillIdx_r + 6'h01);
                    if (count_r == 32'h0)
                    begin
                        exec_r <= lcd_dec_pkg::EX_IDLE;
                        busy_r <= 1'b0;
                    end
                    else
                        count_r <= count_r - 32'h1;
                end
                default:
                begin
                    exec_r <= lcd_dec_pkg::EX_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // text memory: clear sweep or second byte of a text word; contents
    // survive standby and sleep since nothing else writes them
    always_ff @(posedge clk_sys)
    begin
        if (exec_r == lcd_dec_pkg::EX_CLEAR && fillIdx_r < 6'h3F)
            textMem[fillIdx_r] <= `SPACE_WORD;
        else if (exec_r == lcd_dec_pkg::EX_CLEAR)
            textMem[6'h3F] <= `SPACE_WORD;
        else if (wordDone && target_r == lcd_dec_pkg::TGT_TEXT)
            textMem[ac_r[5:0]] <= {hiByte_r, cmd};
    end

    // address counter, word pairing and bitmap address phases
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ac_r <= `AC_RESET;
            row_r <= `AC_RESET;
            target_r <= lcd_dec_pkg::TGT_TEXT;
            wordPhase_r <= 1'b0;
            gfxPhase_r <= 1'b0;
            hiByte_r <= 8'h00;
        end
        else if (cmdFire)
        begin
            wordPhase_r <= 1'b0;
            if (cmd[7] && !ext_r)
            begin
                ac_r <= cmd[6:0] & `TEXT_ADDR_MASK;
                target_r <= lcd_dec_pkg::TGT_TEXT;
            end
            else if (cmd[7] && !gfxPhase_r)
            begin
                ac_r <= cmd[6:0];
                row_r <= cmd[6:0];
                gfxPhase_r <= 1'b1;
                target_r <= lcd_dec_pkg::TGT_BITMAP;
            end
            else if (cmd[7])
            begin
                ac_r <= cmd[6:0] & `HORZ_MASK;
                gfxPhase_r <= 1'b0;
            end
            else if (cmd[6] && !scrollSel_r && ext_r)
            begin
                ac_r <= cmd[6:0] & `ICON_ADDR_MASK;
                target_r <= lcd_dec_pkg::TGT_ICON;
            end
            else if (cmd[6] && !scrollSel_r)
            begin
                ac_r <= {1'b0, cmd[5:0]};
                target_r <= lcd_dec_pkg::TGT_GLYPH;
            end
            else if (cmd[7:4] == 4'h1 && !ext_r
                     && !cmd[`SHIFT_TARGET_BIT])
                ac_r <= stepAddr(ac_r, cmd[`SHIFT_DIR_BIT]);
            else if (cmd[7:1] == 7'h01 && !ext_r)
                ac_r <= `AC_RESET;
            else if (cmd == 8'h01 && !ext_r)
                ac_r <= `AC_RESET;
        end
        else if (dataFire && !wordPhase_r)
        begin
            hiByte_r <= cmd;
            wordPhase_r <= 1'b1;
        end
        else if (wordDone)
        begin
            wordPhase_r <= 1'b0;
            if (target_r == lcd_dec_pkg::TGT_BITMAP)
                ac_r <= 7'(ac_r + 7'h01) & `HORZ_MASK;
            else
                ac_r <= stepAddr(ac_r, incDir_r);
        end
        else if (rdStep)
            ac_r <= stepAddr(ac_r, incDir_r);
    end

    // mode bits: width, set select, entry mode, scroll select
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            width8_r <= 1'b1;
            ext_r <= 1'b0;
            incDir_r <= 1'b1;
            entryShift_r <= 1'b0;
            scrollSel_r <= 1'b0;
        end
        else if (cmdFire)
        begin
            if (cmd[7:5] == 3'b001)
            begin
                width8_r <= cmd[`FS_WIDTH_BIT];
                ext_r <= cmd[`FS_SET_BIT];
            end
            else if (!ext_r && cmd[7:2] == 6'h01)
            begin
                incDir_r <= cmd[1];
                entryShift_r <= cmd[0];
            end
            else if (!ext_r && cmd == 8'h01)
                incDir_r <= 1'b1;
            else if (ext_r && cmd[7:1] == 7'h01)
                scrollSel_r <= cmd[0];
        end
    end

    // panel controls; any instruction but standby itself ends standby
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            panel_r <= '0;
            panel_r.displayOn <= 1'b0;
            revIdx_r <= `REV_IDX_RESET;
        end
        else if (cmdFire)
        begin
            panel_r.standby <= ext_r && cmd == 8'h01;
            if (cmd[7:5] == 3'b001 && ext_r)
                panel_r.graphicOn <= cmd[`FS_GFX_BIT];
            else if (ext_r && cmd[7:2] == 6'h01)
            begin
                revIdx_r <= cmd[1:0];
                panel_r.reversed[cmd[1:0]] <=
                    ~panel_r.reversed[cmd[1:0]];
            end
            else if (ext_r && cmd[7:3] == 5'h01)
                panel_r.sleeping <= ~cmd[2];
            else if (cmd[7:6] == 2'b01 && scrollSel_r)
            begin
                panel_r.scroll <= cmd[5:0];
                panel_r.topLine <= cmd[5:4];
            end
            else if (!ext_r && cmd[7:3] == 5'h01)
            begin
                panel_r.displayOn <= cmd[2];
                panel_r.cursorOn <= cmd[1];
                panel_r.blinkOn <= cmd[0];
            end
            else if (!ext_r && cmd[7:4] == 4'h1 && cmd[`SHIFT_TARGET_BIT])
                panel_r.shift <= stepPos(panel_r.shift,
                                         cmd[`SHIFT_DIR_BIT]);
            else if (!ext_r && cmd[7:1] == 7'h01)
                panel_r.shift <= 6'h00;
        end
        else if (wordDone && entryShift_r)
            panel_r.shift <= stepPos(panel_r.shift, ~incDir_r);
    end

    // read data source; non-text memories are not held here
    assign rdWord = (target_r == lcd_dec_pkg::TGT_TEXT)
                    ? textMem[ac_r[5:0]] : 16'h0000;
    assign rdByte = rdByteSel_r ? rdWord[7:0] : rdWord[15:8];

    // read path: status or data byte, nibbled on a 4-bit bus
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            dbOut_r <= 8'h00;
            dbOe_r <= 1'b0;
            rdNib_r <= 1'b0;
            rdByteSel_r <= 1'b0;
            primed_r <= 1'b0;
        end
        else
        begin
            dbOe_r <= readActive;
            if (readStart)
            begin
                if (!xfer.isData && !rdNib_r)
                    dbOut_r <= width8_r ? {busy_r, ac_r}
                               : {busy_r, ac_r[6:4], 4'h0};
                else if (!xfer.isData)
                    dbOut_r <= {ac_r[3:0], 4'h0};
                else if (width8_r)
                    dbOut_r <= rdByte;
                else if (!rdNib_r)
                    dbOut_r <= {rdByte[7:4], 4'h0};
                else
                    dbOut_r <= {rdByte[3:0], 4'h0};
            end
            if (readEnd && !width8_r)
                rdNib_r <= ~rdNib_r;
            if (cmdFire)
            begin
                primed_r <= 1'b0;
                rdByteSel_r <= 1'b0;
            end
            else if (rdByteDone && xfer.isData && !primed_r)
                primed_r <= 1'b1;
            else if (rdByteDone && xfer.isData)
                rdByteSel_r <= ~rdByteSel_r;
        end
    end

    // outputs straight from flops
    assign dbOut = dbOut_r;
    assign dbOe = dbOe_r;
    assign busyFlag = busy_r;
    assign busWidth8 = width8_r;
    assign extendedSet = ext_r;
    assign addressCounter = ac_r;
    assign bitmapRow = row_r;
    assign memTarget = target_r;
    assign panel = panel_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_accept;
        byteStb_r && !busy_r;
    endsequence

    property p_cursor_move;
        cmdFire && !ext_r && cmd[7:3] == 5'h02
        |=> ac_r == stepAddr($past(ac_r), $past(cmd[2]));
    endproperty
    a_cursor_move: assert property (p_cursor_move)
        else $error("cursor move did not step address counter");

    property p_display_shift;
        cmdFire && !ext_r && cmd[7:3] == 5'h03
        |=> $stable(ac_r) && panel_r.shift != $past(panel_r.shift);
    endproperty
    a_display_shift: assert property (p_display_shift)
        else $error("display shift altered address counter");

    property p_func_set;
        cmdFire && cmd[7:5] == 3'b001
        |=> busWidth8 == $past(cmd[4]) && extendedSet == $past(cmd[2]);
    endproperty
    a_func_set: assert property (p_func_set)
        else $error("function set did not load width or set select");

    property p_busy_ignore;
        byteStb_r && busy_r
        |=> $stable(ext_r) && $stable(panel_r) && $stable(target_r);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore)
        else $error("byte acted on while busy");

    property p_busy_hold;
        s_accept |=> busy_r [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy flag dropped too early");

    property p_first_byte;
        dataFire && !wordPhase_r && !rdStep |=> $stable(ac_r);
    endproperty
    a_first_byte: assert property (p_first_byte)
        else $error("address counter moved after first byte");

    property p_clear;
        cmdFire && !ext_r && cmd == 8'h01
        |=> ac_r == 7'h00 && incDir_r ##1 busy_r [*4];
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not reset counter and direction");

    property p_reverse;
        cmdFire && ext_r && cmd[7:2] == 6'h01
        |=> panel_r.reversed ==
            ($past(panel_r.reversed) ^ (4'h1 << $past(cmd[1:0])));
    endproperty
    a_reverse: assert property (p_reverse)
        else $error("reverse did not toggle the indexed line");

    property p_bitmap_wrap;
        wordDone && target_r == lcd_dec_pkg::TGT_BITMAP && ac_r == 7'h0F
        |=> ac_r == 7'h00;
    endproperty
    a_bitmap_wrap: assert property (p_bitmap_wrap)
        else $error("bitmap horizontal address did not wrap");

    property p_standby_exit;
        cmdFire && cmd != 8'h01 |=> !panel_r.standby;
    endproperty
    a_standby_exit: assert property (p_standby_exit)
        else $error("standby not ended by a following instruction");
endmodule

// file: tb/host_bus_model.sv
// host processor model driving the parallel instruction bus
`timescale 1ns/1ps
module host_bus_model (
    // clock and mode
    input wire logic clk_sys,
    input wire logic busWidth8,
    // read data from the device
    input wire logic [7:0] dbOut,
    // host pins
    output logic hostEnable,
    output logic commandDataSelect,
    output logic readSelect,
    output logic [7:0] dbIn
);
    initial
    begin
        hostEnable = 1'b0;
        commandDataSelect = 1'b0;
        readSelect = 1'b0;
        dbIn = 8'h5A;
    end

    // one enable pulse, five cycles high and four low, pins move at negedge
    task automatic pulse(input logic rs, input logic rw, input logic [7:0] v,
        output logic [7:0] rd);
        @(negedge clk_sys);
        commandDataSelect = rs;
        readSelect = rw;
        dbIn = rw ? ~dbIn : v;
        hostEnable = 1'b1;
        repeat (5) @(negedge clk_sys);
        rd = dbOut;
        hostEnable = 1'b0;
        // released lines must not keep showing the last byte
        dbIn = ~dbIn;
        repeat (4) @(negedge clk_sys);
    endtask

    // one byte; a narrow bus takes it high nibble first on the top lines
    task automatic send(input logic rs, input logic [7:0] v);
        logic [7:0] d;
        if (busWidth8)
            pulse(rs, 1'b0, v, d);
        else
        begin
            pulse(rs, 1'b0, {v[7:4], 4'h0}, d);
            pulse(rs, 1'b0, {v[3:0], 4'h0}, d);
        end
    endtask
endmodule

// file: tb/lcd_instruction_decoder_tb.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
module lcd_instruction_decoder_tb;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic hostEnable;
    logic commandDataSelect;
    logic readSelect;
    logic [7:0] dbIn;
    logic [7:0] dbOut;
    logic [7:0] rd;
    logic dbOe;
    logic busyFlag;
    logic busWidth8;
    logic extendedSet;
    logic [6:0] addressCounter;
    logic [6:0] bitmapRow;
    lcd_dec_pkg::memTarget_t memTarget;
    lcd_dec_pkg::panelCtrl_t panel;
    int errors = 0;
    int total_checks = 0;
    typedef struct {logic [7:0] cmd; logic [6:0] ac;} row_t;
    row_t rows[9] = '{
        '{8'h01, 7'h00},
        '{8'h85, 7'h05},
        '{8'h14, 7'h06},
        '{8'h10, 7'h05},
        '{8'h1C, 7'h05},
        '{8'h18, 7'h05},
        '{8'h7F, 7'h3F},
        '{8'h02, 7'h00},
        '{8'h95, 7'h15}};

    always #20 clk_sys = ~clk_sys;

    // short execution counts keep the run brief
    lcd_instruction_decoder #(.EXEC_CYCLES(20), .CLEAR_CYCLES(70)) dut_u (
        .clk_sys(clk_sys), .reset(reset), .hostEnable(hostEnable),
        .commandDataSelect(commandDataSelect), .readSelect(readSelect),
        .dbIn(dbIn), .dbOut(dbOut), .dbOe(dbOe), .busyFlag(busyFlag),
        .busWidth8(busWidth8), .extendedSet(extendedSet),
        .addressCounter(addressCounter), .bitmapRow(bitmapRow),
        .memTarget(memTarget), .panel(panel));

    host_bus_model host_u (
        .clk_sys(clk_sys), .busWidth8(busWidth8), .dbOut(dbOut),
        .hostEnable(hostEnable), .commandDataSelect(commandDataSelect),
        .readSelect(readSelect), .dbIn(dbIn));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // poll busy with a bound; a hang ends the run
    task automatic waitIdle();
        int n;
        n = 0;
        repeat (8) @(negedge clk_sys);
        while (busyFlag !== 1'b0 && n < 300)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 300)
        begin
            errors++;
            complete_run();
        end
    endtask

    task automatic wr(input logic rs, input logic [7:0] v);
        host_u.send(rs, v);
        waitIdle();
    endtask

    task automatic rdb(input logic rs, output logic [7:0] v);
        host_u.pulse(rs, 1'b1, 8'h00, v);
        waitIdle();
    endtask

    initial
    begin
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        chk({busWidth8, extendedSet, busyFlag}, 8'h04);
        chk({1'b0, addressCounter}, 8'h00);
        foreach (rows[i])
        begin
            wr(1'b0, rows[i].cmd);
            rdb(1'b0, rd);
            chk(rd, {1'b0, rows[i].ac});
        end
        $display("test command table done");
        wr(1'b0, 8'h80);
        wr(1'b0, 8'h06);
        wr(1'b1, 8'h12);
        chk({1'b0, addressCounter}, 8'h00);
        wr(1'b1, 8'h34);
        chk({1'b0, addressCounter}, 8'h01);
        wr(1'b1, 8'h56);
        wr(1'b1, 8'h78);
        wr(1'b0, 8'h04);
        wr(1'b1, 8'hAB);
        wr(1'b1, 8'hCD);
        chk({1'b0, addressCounter}, 8'h01);
        wr(1'b0, 8'h81);
        rdb(1'b1, rd);
        rdb(1'b1, rd);
        chk(rd, 8'h56);
        rdb(1'b1, rd);
        chk(rd, 8'h78);
        chk({1'b0, addressCounter}, 8'h00);
        $display("test data words done");
        // second command lands while the first still executes
        wr(1'b0, 8'h80);
        host_u.send(1'b0, 8'h14);
        repeat (2) @(negedge clk_sys);
        chk({7'h00, busyFlag}, 8'h01);
        host_u.send(1'b0, 8'h14);
        // status read while still busy: flag on top, counter below
        fork
            host_u.pulse(1'b0, 1'b1, 8'h00, rd);
            begin
                repeat (4) @(negedge clk_sys);
                chk({7'h00, dbOe}, 8'h01);
            end
        join
        chk(rd, 8'h81);
        waitIdle();
        chk({1'b0, addressCounter}, 8'h01);
        chk({7'h00, dbOe}, 8'h00);
        $display("test busy refusal done");
        wr(1'b0, 8'h34);
        chk({7'h00, extendedSet}, 8'h01);
        wr(1'b0, 8'h36);
        chk({7'h00, panel.graphicOn}, 8'h01);
        wr(1'b0, 8'h04);
        wr(1'b0, 8'h05);
        wr(1'b0, 8'h04);
        chk({4'h0, panel.reversed}, 8'h02);
        wr(1'b0, 8'h08);
        chk({7'h00, panel.sleeping}, 8'h01);
        wr(1'b0, 8'h0C);
        chk({7'h00, panel.sleeping}, 8'h00);
        wr(1'b0, 8'h01);
        chk({7'h00, panel.standby}, 8'h01);
        wr(1'b0, 8'h03);
        chk({7'h00, panel.standby}, 8'h00);
        wr(1'b0, 8'h65);
        chk({panel.topLine, panel.scroll}, 8'hA5);
        wr(1'b0, 8'h83);
        wr(1'b0, 8'h8F);
        chk({1'b0, bitmapRow}, 8'h03);
        chk({1'b0, addressCounter}, 8'h0F);
        wr(1'b1, 8'h11);
        wr(1'b1, 8'h22);
        chk({1'b0, addressCounter}, 8'h00);
        chk({1'b0, bitmapRow}, 8'h03);
        chk({5'h00, memTarget}, 8'h03);
        chk({7'h00, extendedSet}, 8'h01);
        $display("test extended set done");
        wr(1'b0, 8'h30);
        chk({7'h00, extendedSet}, 8'h00);
        wr(1'b0, 8'h0E);
        chk({5'h00, panel.displayOn, panel.cursorOn, panel.blinkOn},
            8'h06);
        wr(1'b0, 8'h20);
        chk({7'h00, busWidth8}, 8'h00);
        wr(1'b0, 8'h80);
        wr(1'b0, 8'h14);
        chk({1'b0, addressCounter}, 8'h01);
        rdb(1'b0, rd);
        chk(rd, 8'h00);
        rdb(1'b0, rd);
        chk(rd, 8'h10);
        $display("test narrow bus done");
        complete_run();
    end
endmodule
